// ==== rtl/ma_ctrl.sv ====
// Abort handling, measurement status and math/limit post-processing.
// Assumes an acquisition engine on the same clock and a plain register port.
// Overview of operation
// - Abort stops the measurement quickly; complete only when engine reports stopped.
// - Abort clears every pending flag set by initiation.
// - Abort while idle and not continuous is ignored, nothing changes.
// - Abort in a single measurement aborts it and clears pending.
// - Abort in continuous mode aborts, clears pending, then restarts and sets pending.
// - Abort in a block measurement aborts the whole block, clears pending.
// - Abort clears the measuring status bit, except in continuous mode where the restart keeps it set.
// - Aborted result becomes invalid, except an auto-armed totalize count.
// - New data runs enabled stages in order, result goes to output.
// - Result stays valid until recomputed or a relevant setting changes.
// - Totalize and voltage peak measurements bypass all stages.
// - Each stage applies only while enabled, else data passes unchanged.
// - Scaled reply carries 1 to 15 significant digits by resolution.
// - Query with no valid result returns not-a-number and error -230.
// - Query during totalize or peaks returns not-a-number and error -221.
// - Query with math on while measuring blocks until completion or clear.
// - Math input accepts only the sense source, reads back SENS.
// - Recalculate reuses stored data, leaves counts and statistics alone.
// - Recalculate query equals recalculate then result query.
// - Recalculate also reruns the limit stage.
// - Auto-recalc on recomputes on stage commands; off only on data or recalc.
// - Auto-recalc on at power-up, off after reset command, reads ASCII 0/1.
`timescale 1ns/100ps
`include "ma_map.svh"
module ma_ctrl
	import ma_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        acq_done,
	input  wire logic        acq_busy,
	input  wire logic [31:0] acq_data,
	input  wire logic [31:0] scale,
	input  wire logic [31:0] offset,
	input  wire logic [31:0] lim_lo,
	input  wire logic [31:0] lim_hi,
	input  wire logic [3:0]  res_digits,
	output logic             acq_start,
	output logic             acq_abort,
	output logic             cmd_block,
	output logic             reply_valid,
	output logic             reply_nan,
	output logic      [31:0] reply_data,
	output logic      [3:0]  reply_digits
);
	// ==================================================================
	// Helpers
	// Math stage: scale and offset, pass-through when off or bypassed
	function automatic logic [31:0] ma_math(input logic [31:0] d, input logic en);
		logic [63:0] p;
		p = d * scale;
		ma_math = en ? 32'(p[31:0] + offset) : d; // Wraps like the product
	endfunction

	// Status word, shared by the register read and nothing else wider
	function automatic logic [31:0] ma_stat(input ma_st_t q);
		ma_stat = {24'h00_0000, q.state, q.raw_ok, q.fail, q.hold, q.valid,
			q.measuring, q.pending};
	endfunction

	ma_st_t s;
	ma_st_t next_s;
	logic   bypass;
	logic   cmd_hit;
	logic   do_rc;
	logic   want_rply;
	logic   stopped;

	// ==================================================================
	// Next-state logic
	always_comb begin
		next_s = s;
		do_rc = 1'b0;
		want_rply = 1'b0;
		stopped = 1'b0;
		next_s.start = 1'b0;
		next_s.abrt = 1'b0;
		next_s.rply = 1'b0;
		next_s.rdata = 32'h0000_0000;
		cmd_hit = wr && (addr == `MA_CMD);

		// Configuration write; a blocked bus honours only device clear and error-register writes
		if (wr && addr == `MA_CTRL && !s.hold) begin
			next_s.cont = wdata[`MA_C_CONT];
			next_s.tca = wdata[`MA_C_TCA];
			next_s.avg = wdata[`MA_C_AVG];
			next_s.math_en = wdata[`MA_C_MATH];
			next_s.lim_en = wdata[`MA_C_LIM];
			next_s.lfil_en = wdata[`MA_C_LFIL];
			next_s.auto_rc = wdata[`MA_C_AUTO];
			next_s.tot_auto = wdata[`MA_C_TOTAUTO];
			next_s.mtype = ma_mtype_t'(wdata[`MA_C_MTYPE +: 2]);
			if (s.auto_rc)
				do_rc = 1'b1;
			else
				next_s.valid = 1'b0;
		end
		// Only the sense source exists, anything else is refused
		if (wr && addr == `MA_FEED && !s.hold && wdata != `MA_FEED_SENS)
			next_s.err = `MA_ERR_PARAM;
		if (wr && addr == `MA_ERR)
			next_s.err = `MA_ERR_NONE;

		// Commands
		if (cmd_hit && wdata[`MA_K_DCL])
			next_s.hold = 1'b0;
		if (cmd_hit && !s.hold) begin
			if (wdata[`MA_K_RST]) begin
				next_s.cont = 1'b0;
				next_s.math_en = 1'b0;
				next_s.lim_en = 1'b0;
				next_s.lfil_en = 1'b0;
				next_s.avg = 1'b0;
				next_s.tca = 1'b0;
				next_s.auto_rc = `MA_AUTO_RST;
				next_s.valid = 1'b0;
			end
			if (wdata[`MA_K_INIT] && s.state == MA_IDLE) begin
				next_s.start = 1'b1;
				next_s.pending = 1'b1;
				next_s.measuring = 1'b1;
				next_s.state = MA_MEAS;
			end
			// Idle abort falls through untouched
			if (wdata[`MA_K_ABORT] && s.state == MA_MEAS) begin
				next_s.abrt = 1'b1;
				next_s.state = MA_ABORT;
			end
			if (wdata[`MA_K_RECALC] || wdata[`MA_K_QIMM])
				do_rc = 1'b1;
			if (wdata[`MA_K_QIMM])
				want_rply = 1'b1;
			if (wdata[`MA_K_QDATA]) begin
				if (s.math_en && s.measuring)
					next_s.hold = 1'b1;
				else
					want_rply = 1'b1;
			end
		end

		// Measurement cycle
		case (s.state)
			MA_IDLE: begin
				if (s.cont) begin
					next_s.start = 1'b1;
					next_s.pending = 1'b1;
					next_s.measuring = 1'b1;
					next_s.state = MA_MEAS;
				end
			end
			MA_MEAS: begin
				if (acq_done && next_s.state == MA_MEAS) begin
					next_s.raw = acq_data;
					next_s.raw_ok = 1'b1;
					do_rc = 1'b1;
					stopped = 1'b1;
					if (next_s.cont) begin
						next_s.start = 1'b1;
					end else begin
						next_s.pending = 1'b0;
						next_s.measuring = 1'b0;
						next_s.state = MA_IDLE;
					end
				end
			end
			MA_ABORT: begin
				// Complete only once the engine has really stopped
				if (!acq_busy) begin
					stopped = 1'b1;
					next_s.pending = 1'b0;
					next_s.measuring = 1'b0;
					if (s.tot_auto && s.mtype == MA_TOTAL) begin
						next_s.raw = acq_data;
						next_s.raw_ok = 1'b1;
						next_s.res = acq_data;
						next_s.valid = 1'b1;
					end else begin
						next_s.valid = 1'b0;
					end
					if (s.cont) begin
						next_s.start = 1'b1;
						next_s.pending = 1'b1;
						next_s.measuring = 1'b1;
						next_s.state = MA_MEAS;
					end else begin
						next_s.state = MA_IDLE;
					end
				end
			end
			default: begin
				next_s.state = MA_IDLE;
			end
		endcase

		// Stage chain: math then limit; filter and averaging live elsewhere
		bypass = next_s.mtype != MA_NORMAL;
		if (do_rc && next_s.raw_ok && !(s.state == MA_ABORT && stopped)) begin
			next_s.res = ma_math(next_s.raw, next_s.math_en && !bypass);
			next_s.fail = next_s.lim_en && !bypass &&
				(next_s.res < lim_lo || next_s.res > lim_hi);
			next_s.valid = 1'b1;
		end

		// Held query is released by the measurement ending
		if (s.hold && stopped) begin
			next_s.hold = 1'b0;
			want_rply = 1'b1;
		end

		// Reply with not-a-number and error when nothing usable exists
		if (want_rply) begin
			next_s.rply = 1'b1;
			next_s.rdig = (res_digits < `MA_DIG_MIN) ? `MA_DIG_MIN : res_digits;
			if (bypass) begin
				next_s.rnan = 1'b1;
				next_s.rval = `MA_NAN;
				next_s.err = `MA_ERR_SETTING;
			end else if (!next_s.valid) begin
				next_s.rnan = 1'b1;
				next_s.rval = `MA_NAN;
				next_s.err = `MA_ERR_NORES;
			end else begin
				next_s.rnan = 1'b0;
				next_s.rval = next_s.res;
			end
		end

		// Register read, data in the following cycle only
		if (rd) begin
			case (addr)
				`MA_CTRL: next_s.rdata = {22'h00_0000, s.mtype, s.tot_auto, s.auto_rc,
					s.lfil_en, s.lim_en, s.math_en, s.avg, s.tca, s.cont};
				`MA_STAT: next_s.rdata = ma_stat(s);
				`MA_RESULT: next_s.rdata = s.res;
				`MA_ERR: next_s.rdata = {16'h0000, s.err};
				`MA_FEED: next_s.rdata = `MA_FEED_SENS;
				`MA_AUTO: next_s.rdata = s.auto_rc ? `MA_ASCII_1 : `MA_ASCII_0;
				default: next_s.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ==================================================================
	// State register; auto-recalc powers up on
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.state <= MA_IDLE;
			s.auto_rc <= `MA_AUTO_PWRUP;
			s.mtype <= MA_NORMAL;
		end else begin
			s <= next_s;
		end
	end

	// Outputs straight from the state flops
	assign rdata = s.rdata;
	assign acq_start = s.start;
	assign acq_abort = s.abrt;
	assign cmd_block = s.hold;
	assign reply_valid = s.rply;
	assign reply_nan = s.rnan;
	assign reply_data = s.rval;
	assign reply_digits = s.rdig;

	// ==================================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_abort_req;
		wr && addr == `MA_CMD && wdata[`MA_K_ABORT] && !s.hold;
	endsequence
	sequence s_abort_end;
		s.state == MA_ABORT && !acq_busy;
	endsequence

	property p_idle_abort;
		s_abort_req and (s.state == MA_IDLE && !s.cont && !wdata[`MA_K_INIT])
			|=> !acq_abort && s.state == MA_IDLE && !s.pending;
	endproperty
	a_idle_abort: assert property (p_idle_abort) else $error("idle abort acted");

	property p_abort_go;
		(s_abort_req and s.state == MA_MEAS) |=> acq_abort && s.state == MA_ABORT;
	endproperty
	a_abort_go: assert property (p_abort_go) else $error("abort not issued");

	property p_abort_wait;
		s.state == MA_ABORT && acq_busy |=> s.state == MA_ABORT && s.measuring;
	endproperty
	a_abort_wait: assert property (p_abort_wait) else $error("abort ended early");

	property p_abort_clear;
		s_abort_end and !s.cont |=> !s.pending && !s.measuring && s.state == MA_IDLE;
	endproperty
	a_abort_clear: assert property (p_abort_clear) else $error("flags not cleared");

	property p_abort_restart;
		s_abort_end and s.cont |=> acq_start && s.pending && s.state == MA_MEAS;
	endproperty
	a_abort_restart: assert property (p_abort_restart) else $error("no restart");

	property p_abort_invalid;
		s_abort_end and !(s.tot_auto && s.mtype == MA_TOTAL) |=> !s.valid;
	endproperty
	a_abort_invalid: assert property (p_abort_invalid) else $error("result kept");

	property p_hold_quiet;
		s.hold |-> !reply_valid;
	endproperty
	a_hold_quiet: assert property (p_hold_quiet) else $error("reply while held");

	property p_nan_err;
		reply_valid && reply_nan |-> s.err == `MA_ERR_NORES || s.err == `MA_ERR_SETTING;
	endproperty
	a_nan_err: assert property (p_nan_err) else $error("nan without error");

	property p_bypass_nan;
		reply_valid && s.mtype != MA_NORMAL |-> reply_nan;
	endproperty
	a_bypass_nan: assert property (p_bypass_nan) else $error("bypass replied data");

	property p_rst_auto;
		wr && addr == `MA_CMD && wdata[`MA_K_RST] && !s.hold |=> !s.auto_rc;
	endproperty
	a_rst_auto: assert property (p_rst_auto) else $error("auto stays on");

	property p_digits;
		reply_valid |-> reply_digits >= `MA_DIG_MIN;
	endproperty
	a_digits: assert property (p_digits) else $error("digits below one");
endmodule

// ==== rtl/ma_map.svh ====
// Register map, field positions, reset values and codes of the
// abort and post-processing controller. Included by the package user.
// Assumes a byte-addressed plain register port with 32-bit data.
`ifndef MA_MAP_SVH
`define MA_MAP_SVH
// Register byte offsets
`define MA_CTRL        8'h00
`define MA_CMD         8'h04
`define MA_STAT        8'h08
`define MA_RESULT      8'h0C
`define MA_ERR         8'h10
`define MA_FEED        8'h14
`define MA_AUTO        8'h18
// Control fields
`define MA_C_CONT      0
`define MA_C_TCA       1
`define MA_C_AVG       2
`define MA_C_MATH      3
`define MA_C_LIM       4
`define MA_C_LFIL      5
`define MA_C_AUTO      6
`define MA_C_TOTAUTO   7
`define MA_C_MTYPE     8
// Command bits, write one to act
`define MA_K_INIT      0
`define MA_K_ABORT     1
`define MA_K_RECALC    2
`define MA_K_QDATA     3
`define MA_K_QIMM      4
`define MA_K_RST       5
`define MA_K_DCL       6
// Reset values and codes
`define MA_AUTO_PWRUP  1'b1
`define MA_AUTO_RST    1'b0
`define MA_FEED_SENS   32'h5345_4E53
`define MA_ASCII_0     32'h0000_0030
`define MA_ASCII_1     32'h0000_0031
`define MA_NAN         32'h7E95_1C39
`define MA_ERR_NONE    16'h0000
`define MA_ERR_NORES   16'hFF1A
`define MA_ERR_SETTING 16'hFF23
`define MA_ERR_PARAM   16'hFF20
`define MA_DIG_MIN     4'h1
`define MA_DIG_MAX     4'hF
`endif

// ==== rtl/ma_pkg.sv ====
// Types of the abort and post-processing controller.
// Assumes ma_map.svh supplies all numeric constants.
package ma_pkg;
	// Measurement cycle, Gray order idle-measure-abort
	typedef enum logic [1:0] {
		MA_IDLE  = 2'b00,
		MA_MEAS  = 2'b01,
		MA_ABORT = 2'b11
	} ma_state_t;
	// Active measurement kind
	typedef enum logic [1:0] {
		MA_NORMAL = 2'b00,
		MA_TOTAL  = 2'b01,
		MA_VPEAK  = 2'b10
	} ma_mtype_t;
	// Whole controller state
	typedef struct packed {
		ma_state_t   state;
		logic        pending;
		logic        measuring;
		logic        valid;
		logic        raw_ok;
		logic        hold;
		logic        cont;
		logic        tca;
		logic        avg;
		logic        math_en;
		logic        lim_en;
		logic        lfil_en;
		logic        auto_rc;
		logic        tot_auto;
		ma_mtype_t   mtype;
		logic [31:0] raw;
		logic [31:0] res;
		logic        fail;
		logic [15:0] err;
		logic [31:0] rdata;
		logic        start;
		logic        abrt;
		logic        rply;
		logic        rnan;
		logic [31:0] rval;
		logic [3:0]  rdig;
	} ma_st_t;
endpackage

// ==== verification/ma_acq_model.sv ====
// Behavioural acquisition engine that stands beside the controller.
// Assumes one shared clock; the run length is latched at each start.
`timescale 1ns/100ps
module ma_acq_model (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       acq_start,
	input  wire logic       acq_abort,
	input  wire logic [7:0] len,
	output logic            acq_done,
	output logic            acq_busy
);
	logic [7:0] cnt;
	logic [1:0] stop;

	// ==========================================================
	// Run, finish or stop late, as a real engine would
	// Busy stays high from start until done or stop, never shorter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acq_done <= 1'b0;
			acq_busy <= 1'b0;
			cnt      <= 8'h00;
			stop     <= 2'b00;
		end else begin
			acq_done <= 1'b0;
			if (acq_start) begin
				acq_busy <= 1'b1;
				cnt      <= len;
				stop     <= 2'b00;
			end else if (acq_abort) begin
				stop <= 2'b10; // Two cycles late, so abort must wait
			end else if (stop != 2'b00) begin
				stop <= stop - 2'b01;
				if (stop == 2'b01) begin
					acq_busy <= 1'b0;
				end
			end else if (acq_busy && cnt == 8'h00) begin
				acq_done <= 1'b1;
				acq_busy <= 1'b0;
			end else if (acq_busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// ==== verification/measurement_abort_and_math_postproc_tb.sv ====
// Self-checking bench of the abort and post-processing controller.
// Assumes ma_acq_model as engine and the register map of ma_map.svh.
`timescale 1ns/100ps
`include "ma_map.svh"
module measurement_abort_and_math_postproc_tb;
	logic        clk, rst_n, wr, rd, acq_done, acq_busy, acq_start, acq_abort;
	logic        cmd_block, reply_valid, reply_nan;
	logic [7:0]  addr, len;
	logic [31:0] wdata, rdata, acq_data, scale, offset, lim_lo, lim_hi, reply_data, v;
	logic [3:0]  res_digits, reply_digits;
	int          n_errors, checks, n_start, n_abort, n_reply, i, r;

	ma_ctrl DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .acq_done(acq_done), .acq_busy(acq_busy), .acq_data(acq_data),
		.scale(scale), .offset(offset), .lim_lo(lim_lo), .lim_hi(lim_hi),
		.res_digits(res_digits), .acq_start(acq_start), .acq_abort(acq_abort),
		.cmd_block(cmd_block), .reply_valid(reply_valid), .reply_nan(reply_nan),
		.reply_data(reply_data), .reply_digits(reply_digits));
	ma_acq_model ENG (.clk(clk), .rst_n(rst_n), .acq_start(acq_start),
		.acq_abort(acq_abort), .len(len), .acq_done(acq_done), .acq_busy(acq_busy));

	// ==========================================================
	// Clock, pulse counters and watchdog
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	always @(posedge clk) begin
		n_start += (acq_start === 1'b1);
		n_abort += (acq_abort === 1'b1);
		n_reply += (reply_valid === 1'b1);
	end
	initial begin
		#(40 * 30000);
		n_errors++;
		end_sim;
	end

	// ==========================================================
	// Bus tasks and comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata; // Read data stand only in this cycle
	endtask
	task automatic wait_reply;
		for (int k = 0; k < 60 && reply_valid !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		chk({31'h0, reply_valid}, 32'h0000_0001);
	endtask
	task automatic stop_all;
		wr_reg(`MA_CTRL, 32'h0000_0040);
		wr_reg(`MA_CMD, 32'h0000_0002);
		repeat (10) @(posedge clk);
	endtask
	// Start, abort and compare status; engine stops two cycles late
	task automatic run_abort(input logic [31:0] ctrl, input logic [31:0] stat,
		input int starts);
		int s, a;
		wr_reg(`MA_CTRL, ctrl);
		wr_reg(`MA_CMD, 32'h0000_0001);
		rd_reg(`MA_STAT);
		chk(v & 32'h0000_0003, 32'h0000_0003);
		s = n_start;
		a = n_abort;
		wr_reg(`MA_CMD, 32'h0000_0002);
		repeat (10) @(posedge clk);
		chk(32'(n_abort - a), 32'h0000_0001);
		chk(32'(n_start - s), 32'(starts));
		rd_reg(`MA_STAT);
		chk(v & 32'h0000_0007, stat);
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, mismatches %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{wr, rd, addr, wdata} = '0;
		{acq_data, scale, offset} = {32'h0000_000A, 32'h0000_0003, 32'h0000_0005};
		{lim_lo, lim_hi, res_digits, len} = {32'h0, 32'h0000_0028, 4'h7, 8'hC8};
		rst_n = 1'b0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		rd_reg(`MA_AUTO);
		chk(v, `MA_ASCII_1);
		rd_reg(`MA_FEED);
		chk(v, `MA_FEED_SENS);
		rd_reg(8'h1C);
		chk(v, 32'h0);
		// Abort while idle leaves everything as it was
		wr_reg(`MA_CMD, 32'h0000_0002);
		rd_reg(`MA_STAT);
		chk(v, 32'h0);
		chk(32'(n_abort), 32'h0);
		wr_reg(`MA_CMD, 32'h0000_0008);
		wait_reply;
		chk({31'h0, reply_nan}, 32'h0000_0001);
		chk(reply_data, `MA_NAN);
		rd_reg(`MA_ERR);
		chk(v, {16'h0, `MA_ERR_NORES});
		// Single, block and continuous aborts from one table
		for (i = 0; i < 3; i++) begin
			run_abort(i == 0 ? 32'h40 : i == 1 ? 32'h46 : 32'h41, i == 2 ? 32'h3 : 32'h0,
				i == 2 ? 1 : 0);
			stop_all;
		end
		// Auto-armed totalize keeps its count; a totalize query returns not-a-number and error -221
		run_abort(32'h0000_01C0, 32'h0000_0004, 0);
		wr_reg(`MA_CMD, 32'h0000_0008);
		wait_reply;
		chk({31'h0, reply_nan}, 32'h0000_0001);
		rd_reg(`MA_ERR);
		chk(v, {16'h0, `MA_ERR_SETTING});
		stop_all;
		// Held query blocks settings until the measurement ends
		@(posedge clk);
		len <= 8'h0A;
		wr_reg(`MA_CTRL, 32'h0000_0048);
		wr_reg(`MA_CMD, 32'h0000_0001);
		wr_reg(`MA_CMD, 32'h0000_0008);
		chk({31'h0, cmd_block}, 32'h0000_0001);
		wr_reg(`MA_CTRL, 32'h0000_0040);
		rd_reg(`MA_CTRL);
		chk(v, 32'h0000_0048);
		wait_reply;
		chk(reply_data, 32'h0000_0023);
		chk({28'h0, reply_digits}, 32'h0000_0007);
		rd_reg(`MA_STAT);
		chk({31'h0, cmd_block}, 32'h0);
		// Math off passes raw data; auto-recalc applies it at once
		wr_reg(`MA_CTRL, 32'h0000_0040);
		wr_reg(`MA_CMD, 32'h0000_0008);
		wait_reply;
		chk(reply_data, 32'h0000_000A);
		wr_reg(`MA_CTRL, 32'h0000_0018); // Limit on so the new result can fail
		@(posedge clk);
		scale <= 32'h0000_0004;
		wr_reg(`MA_CMD, 32'h0000_0010);
		wait_reply;
		chk(reply_data, 32'h0000_002D);
		rd_reg(`MA_STAT);
		chk(v & 32'h0000_0014, 32'h0000_0014);
		// With auto-recalc off a setting change invalidates
		wr_reg(`MA_CTRL, 32'h0000_0008);
		rd_reg(`MA_STAT);
		chk(v & 32'h0000_0004, 32'h0);
		wr_reg(`MA_ERR, 32'h0);
		wr_reg(`MA_FEED, 32'h0000_1234);
		rd_reg(`MA_ERR);
		chk(v, {16'h0, `MA_ERR_PARAM});
		wr_reg(`MA_CTRL, 32'h0000_0040);
		rd_reg(`MA_AUTO);
		chk(v, `MA_ASCII_1);
		wr_reg(`MA_CMD, 32'h0000_0020);
		rd_reg(`MA_AUTO);
		chk(v, `MA_ASCII_0);
		// Device clear drops a held query without a reply
		@(posedge clk);
		len <= 8'h64;
		wr_reg(`MA_CTRL, 32'h0000_0008);
		wr_reg(`MA_CMD, 32'h0000_0001);
		r = n_reply;
		wr_reg(`MA_CMD, 32'h0000_0008);
		chk({31'h0, cmd_block}, 32'h0000_0001);
		wr_reg(`MA_CMD, 32'h0000_0040);
		rd_reg(`MA_STAT);
		chk({31'h0, cmd_block}, 32'h0);
		chk(32'(n_reply - r), 32'h0);
		end_sim;
	end
endmodule
